// ==== logic/ornt_defines.vh ====
// Register offsets, field positions, reset values and filter constants.
// Included by the orientation register bank and its high-pass filter.
`ifndef ORNT_DEFINES_VH
`define ORNT_DEFINES_VH

`define ORNT_OFS_DATA_CFG      8'h16
`define ORNT_OFS_HP_CUTOFF     8'h17
`define ORNT_OFS_STATUS        8'h18
`define ORNT_OFS_PREVIOUS      8'h19
`define ORNT_OFS_CONFIG        8'h1A

`define ORNT_DCFG_SRC_BIT      7
`define ORNT_DCFG_ZEN_BIT      2
`define ORNT_DCFG_YEN_BIT      1
`define ORNT_DCFG_XEN_BIT      0
`define ORNT_DCFG_RESET        1'h0

`define ORNT_HP_SEL_MSB        1
`define ORNT_HP_SEL_LSB        0
`define ORNT_HP_RESET          2'h0

`define ORNT_ST_CHANGE_BIT     7
`define ORNT_ST_LOCK_BIT       6
`define ORNT_ST_PL_MSB         4
`define ORNT_ST_PL_LSB         2
`define ORNT_ST_BF_MSB         1
`define ORNT_ST_BF_LSB         0
`define ORNT_LOCK_RESET        1'h0
`define ORNT_BF_RESET          2'h0
`define ORNT_PL_RESET          3'h0

`define ORNT_CFG_DBMODE_BIT    7
`define ORNT_CFG_EN_BIT        6
`define ORNT_CFG_OFS_MSB       2
`define ORNT_CFG_OFS_LSB       0
`define ORNT_CFG_DBMODE_RESET  1'h1
`define ORNT_CFG_EN_RESET      1'h0
`define ORNT_CFG_OFS_RESET     3'h3

`define ORNT_SAMPLE_W          12
`define ORNT_FRAC_W            12
`define ORNT_HP_BASE_SHIFT     3'h4

`endif

// ==== logic/ornt_highpass.v ====
// First-order high-pass filter for one acceleration axis.
// Assumes one sample_valid_in pulse per output data period on mclk_in.
`timescale 1ns/1ns
`include "ornt_defines.vh"

module ornt_highpass (
	input  wire        mclk_in,
	input  wire        rstn_in,
	input  wire        sample_valid_in,
	input  wire [11:0] sample_in,
	input  wire [1:0]  cutoff_sel_in,
	output reg  [11:0] delta_out
);

	localparam [11:0] SAT_MAX = 12'h7FF;
	localparam [11:0] SAT_MIN = 12'h800;

	reg  signed [23:0] lowpass_q;
	wire signed [24:0] sample_ext;
	wire signed [24:0] diff;
	wire        [2:0]  shift;
	wire signed [24:0] step;
	wire signed [24:0] lowpass_sum;
	wire signed [12:0] delta_full;

	// The corner is a fixed fraction of the update rate, so it follows the data rate.
	assign shift       = `ORNT_HP_BASE_SHIFT + {1'b0, cutoff_sel_in};
	assign sample_ext  = {sample_in[11], sample_in, 12'h000};
	assign diff        = sample_ext - {lowpass_q[23], lowpass_q};
	assign step        = diff >>> shift;
	assign lowpass_sum = {lowpass_q[23], lowpass_q} + step;
	assign delta_full  = diff[24:12];

	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lowpass_q <= 24'h000000;
			delta_out <= 12'h000;
		end else if (sample_valid_in) begin
			lowpass_q <= lowpass_sum[23:0];
			// Saturate rather than wrap when the difference exceeds the output range.
			if (delta_full[12] != delta_full[11]) begin
				delta_out <= delta_full[12] ? SAT_MIN : SAT_MAX;
			end else begin
				delta_out <= delta_full[11:0];
			end
		end
	end

endmodule

// ==== logic/ornt_regbank.v ====
// Register bank for sample data configuration, high-pass cutoff and orientation status.
// Assumes the serial bus logic, the orientation engine, the sample path and the
// interrupt controller all run on mclk_in; reg_rd_in and reg_wr_in are one-cycle strobes.
`timescale 1ns/1ns
`include "ornt_defines.vh"

module ornt_regbank (
	input  wire        mclk_in,
	input  wire        rstn_in,
	input  wire [7:0]  reg_addr_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	input  wire [7:0]  reg_wdata_in,
	output reg  [7:0]  reg_rdata_out,
	output reg         reg_rvalid_out,
	input  wire        sample_valid_in,
	input  wire [11:0] live_x_in,
	input  wire [11:0] live_y_in,
	input  wire [11:0] live_z_in,
	input  wire [11:0] stored_x_in,
	input  wire [11:0] stored_y_in,
	input  wire [11:0] stored_z_in,
	output reg  [11:0] sample_x_out,
	output reg  [11:0] sample_y_out,
	output reg  [11:0] sample_z_out,
	output reg         x_new_data_event_out,
	output reg         y_new_data_event_out,
	output reg         z_new_data_event_out,
	output wire [11:0] delta_x_out,
	output wire [11:0] delta_y_out,
	output wire [11:0] delta_z_out,
	output reg  [1:0]  cutoff_select_out,
	input  wire        orient_update_in,
	input  wire        orient_lockout_in,
	input  wire [1:0]  orient_back_front_in,
	input  wire [2:0]  orient_portrait_landscape_in,
	input  wire        orientation_interrupt_enable_in,
	output reg         orientation_interrupt_source_out,
	output reg         orientation_detect_enable_out,
	output reg         debounce_counter_mode_out,
	output reg  [2:0]  lockout_threshold_offset_out
);

	// Register bus access states, one-hot.
	localparam [2:0] ST_IDLE  = 3'h1;
	localparam [2:0] ST_WRITE = 3'h2;
	localparam [2:0] ST_READ  = 3'h4;

	reg  [2:0]  bus_state;
	reg         output_source_select_q;
	reg         z_new_data_flag_enable_q;
	reg         y_new_data_flag_enable_q;
	reg         x_new_data_flag_enable_q;
	reg  [1:0]  cutoff_sel_q;
	reg         orientation_change_flag_q;
	reg         orientation_change_flag_d;
	reg         tilt_lockout_bit_q;
	reg  [1:0]  back_front_field_q;
	reg  [2:0]  portrait_landscape_field_q;
	reg         prev_lockout_q;
	reg  [1:0]  prev_back_front_q;
	reg  [2:0]  prev_portrait_landscape_q;
	reg         debounce_counter_mode_q;
	reg         orientation_detect_enable_q;
	reg  [2:0]  lockout_threshold_offset_q;
	reg  [7:0]  rdata_d;
	wire        wr_data_cfg;
	wire        wr_hp_cutoff;
	wire        wr_config;
	wire        rd_status;
	wire        orient_take;
	wire        orient_changed;
	wire [35:0] live_bus;
	wire [35:0] delta_bus;

	// Address match shared by every write and read decode.
	function addr_hit;
		input [7:0] addr;
		input [7:0] offset;
		begin
			addr_hit = (addr == offset);
		end
	endfunction

	// Packs orientation fields into the common status byte layout.
	function [7:0] pack_orient;
		input       flag;
		input       lock;
		input [1:0] bf;
		input [2:0] pl;
		reg   [7:0] v;
		begin
			v = 8'h00;
			v[`ORNT_ST_CHANGE_BIT] = flag;
			v[`ORNT_ST_LOCK_BIT] = lock;
			v[`ORNT_ST_PL_MSB:`ORNT_ST_PL_LSB] = pl;
			v[`ORNT_ST_BF_MSB:`ORNT_ST_BF_LSB] = bf;
			pack_orient = v;
		end
	endfunction

	// The strobes are decoded afresh each cycle, so no bus state loops back on itself.
	// A write strobe wins when both strobes are high, and that read is dropped.
	always @(*) begin
		case ({reg_wr_in, reg_rd_in})
			2'b00: begin
				bus_state = ST_IDLE;
			end
			2'b01: begin
				bus_state = ST_READ;
			end
			default: begin
				bus_state = ST_WRITE;
			end
		endcase
	end

	// read-only ignored: only writable offsets decode a write.
	assign wr_data_cfg  = (bus_state == ST_WRITE) && addr_hit(reg_addr_in, `ORNT_OFS_DATA_CFG);
	assign wr_hp_cutoff = (bus_state == ST_WRITE) && addr_hit(reg_addr_in, `ORNT_OFS_HP_CUTOFF);
	assign wr_config    = (bus_state == ST_WRITE) && addr_hit(reg_addr_in, `ORNT_OFS_CONFIG);
	assign rd_status    = (bus_state == ST_READ) && addr_hit(reg_addr_in, `ORNT_OFS_STATUS);

	assign orient_take = orient_update_in && orientation_detect_enable_q;

	assign orient_changed = orient_take &&
		((orient_lockout_in != tilt_lockout_bit_q) ||
		 (orient_back_front_in != back_front_field_q) ||
		 (orient_portrait_landscape_in != portrait_landscape_field_q));

	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			output_source_select_q   <= `ORNT_DCFG_RESET;
			z_new_data_flag_enable_q <= `ORNT_DCFG_RESET;
			y_new_data_flag_enable_q <= `ORNT_DCFG_RESET;
			x_new_data_flag_enable_q <= `ORNT_DCFG_RESET;
			cutoff_sel_q             <= `ORNT_HP_RESET;
		end else begin
			if (wr_data_cfg) begin
				output_source_select_q   <= reg_wdata_in[`ORNT_DCFG_SRC_BIT];
				z_new_data_flag_enable_q <= reg_wdata_in[`ORNT_DCFG_ZEN_BIT];
				y_new_data_flag_enable_q <= reg_wdata_in[`ORNT_DCFG_YEN_BIT];
				x_new_data_flag_enable_q <= reg_wdata_in[`ORNT_DCFG_XEN_BIT];
			end
			if (wr_hp_cutoff) begin
				cutoff_sel_q <= reg_wdata_in[`ORNT_HP_SEL_MSB:`ORNT_HP_SEL_LSB];
			end
		end
	end

	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			debounce_counter_mode_q     <= `ORNT_CFG_DBMODE_RESET;
			orientation_detect_enable_q <= `ORNT_CFG_EN_RESET;
			lockout_threshold_offset_q  <= `ORNT_CFG_OFS_RESET;
		end else if (wr_config) begin
			debounce_counter_mode_q     <= reg_wdata_in[`ORNT_CFG_DBMODE_BIT];
			orientation_detect_enable_q <= reg_wdata_in[`ORNT_CFG_EN_BIT];
			lockout_threshold_offset_q  <= reg_wdata_in[`ORNT_CFG_OFS_MSB:`ORNT_CFG_OFS_LSB];
		end
	end

	always @(*) begin
		orientation_change_flag_d = orientation_change_flag_q;
		if (rd_status) begin
			orientation_change_flag_d = 1'b0;
		end
		if (orient_changed) begin
			orientation_change_flag_d = 1'b1;
		end
	end

	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			orientation_change_flag_q  <= 1'b0;
			tilt_lockout_bit_q         <= `ORNT_LOCK_RESET;
			back_front_field_q         <= `ORNT_BF_RESET;
			portrait_landscape_field_q <= `ORNT_PL_RESET;
			prev_lockout_q             <= `ORNT_LOCK_RESET;
			prev_back_front_q          <= `ORNT_BF_RESET;
			prev_portrait_landscape_q  <= `ORNT_PL_RESET;
		end else begin
			orientation_change_flag_q <= orientation_change_flag_d;
			if (orient_take) begin
				tilt_lockout_bit_q         <= orient_lockout_in;
				back_front_field_q         <= orient_back_front_in;
				portrait_landscape_field_q <= orient_portrait_landscape_in;
			end
			if (orient_changed) begin
				prev_lockout_q            <= tilt_lockout_bit_q;
				prev_back_front_q         <= back_front_field_q;
				prev_portrait_landscape_q <= portrait_landscape_field_q;
			end
		end
	end

	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			orientation_interrupt_source_out <= 1'b0;
		end else begin
			orientation_interrupt_source_out <= orientation_change_flag_d &&
				orientation_interrupt_enable_in;
		end
	end

	always @(*) begin
		rdata_d = 8'h00;
		if (addr_hit(reg_addr_in, `ORNT_OFS_DATA_CFG)) begin
			rdata_d[`ORNT_DCFG_SRC_BIT] = output_source_select_q;
			rdata_d[`ORNT_DCFG_ZEN_BIT] = z_new_data_flag_enable_q;
			rdata_d[`ORNT_DCFG_YEN_BIT] = y_new_data_flag_enable_q;
			rdata_d[`ORNT_DCFG_XEN_BIT] = x_new_data_flag_enable_q;
		end else if (addr_hit(reg_addr_in, `ORNT_OFS_HP_CUTOFF)) begin
			rdata_d[`ORNT_HP_SEL_MSB:`ORNT_HP_SEL_LSB] = cutoff_sel_q;
		end else if (addr_hit(reg_addr_in, `ORNT_OFS_STATUS)) begin
			rdata_d = pack_orient(orientation_change_flag_q, tilt_lockout_bit_q,
				back_front_field_q, portrait_landscape_field_q);
		end else if (addr_hit(reg_addr_in, `ORNT_OFS_PREVIOUS)) begin
			rdata_d = pack_orient(1'b0, prev_lockout_q, prev_back_front_q,
				prev_portrait_landscape_q);
		end else if (addr_hit(reg_addr_in, `ORNT_OFS_CONFIG)) begin
			rdata_d[`ORNT_CFG_DBMODE_BIT] = debounce_counter_mode_q;
			rdata_d[`ORNT_CFG_EN_BIT] = orientation_detect_enable_q;
			rdata_d[`ORNT_CFG_OFS_MSB:`ORNT_CFG_OFS_LSB] = lockout_threshold_offset_q;
		end
	end

	// Read data is captured in the cycle of the strobe and shown one cycle later.
	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rdata_out  <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= (bus_state == ST_READ);
			if (bus_state == ST_READ) begin
				reg_rdata_out <= rdata_d;
			end
		end
	end

	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sample_x_out         <= 12'h000;
			sample_y_out         <= 12'h000;
			sample_z_out         <= 12'h000;
			x_new_data_event_out <= 1'b0;
			y_new_data_event_out <= 1'b0;
			z_new_data_event_out <= 1'b0;
		end else begin
			if (sample_valid_in) begin
				sample_x_out <= output_source_select_q ? stored_x_in : live_x_in;
				sample_y_out <= output_source_select_q ? stored_y_in : live_y_in;
				sample_z_out <= output_source_select_q ? stored_z_in : live_z_in;
			end
			x_new_data_event_out <= sample_valid_in && x_new_data_flag_enable_q;
			y_new_data_event_out <= sample_valid_in && y_new_data_flag_enable_q;
			z_new_data_event_out <= sample_valid_in && z_new_data_flag_enable_q;
		end
	end

	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cutoff_select_out             <= `ORNT_HP_RESET;
			orientation_detect_enable_out <= `ORNT_CFG_EN_RESET;
			debounce_counter_mode_out     <= `ORNT_CFG_DBMODE_RESET;
			lockout_threshold_offset_out  <= `ORNT_CFG_OFS_RESET;
		end else begin
			cutoff_select_out             <= cutoff_sel_q;
			orientation_detect_enable_out <= orientation_detect_enable_q;
			debounce_counter_mode_out     <= debounce_counter_mode_q;
			lockout_threshold_offset_out  <= lockout_threshold_offset_q;
		end
	end

	// The filters always see live samples, whatever the source select says.
	assign live_bus = {live_z_in, live_y_in, live_x_in};

	genvar axis;
	generate
		for (axis = 0; axis < 3; axis = axis + 1) begin : g_axis
			ornt_highpass u_hp (
				.mclk_in         (mclk_in),
				.rstn_in         (rstn_in),
				.sample_valid_in (sample_valid_in),
				.sample_in       (live_bus[axis*12 +: 12]),
				.cutoff_sel_in   (cutoff_sel_q),
				.delta_out       (delta_bus[axis*12 +: 12])
			);
		end
	endgenerate

	assign delta_x_out = delta_bus[11:0];
	assign delta_y_out = delta_bus[23:12];
	assign delta_z_out = delta_bus[35:24];

endmodule

// ==== testbench/orientation_status_and_data_config_tb_top.sv ====
// Self-checking bench for the orientation register bank.
// Assumes the host model and monitor files are compiled first.
`timescale 1ns/1ns
module orientation_status_and_data_config_tb_top;
	logic        mclk_in = 0;
	logic        rstn_in = 0;
	logic        valid = 0, upd = 0, lo = 0, ien = 1, ok;
	logic [11:0] lx = 0, ly = 0, lz = 0, sx = 0, sy = 0, sz = 0;
	logic [1:0]  bf = 0;
	logic [2:0]  pl = 0;
	logic [7:0]  v, e, prev;
	logic [31:0] seed = 32'hFA1F4520;
	wire  [7:0]  addr, wdata, rdata;
	wire  [11:0] ox, oy, oz, dx, dy, dz;
	wire  [1:0]  cut;
	wire  [2:0]  gof;
	wire         wr, rd, rvalid, ex, ey, ez, isrc, den, dbm;
	int          err_count = 0, n_compared = 0;
	int          lp [3] = '{0, 0, 0};
	always #20 mclk_in = ~mclk_in;
	ornt_host_model u_host (.mclk_in, .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
		.reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
	ornt_regbank u_dut (.mclk_in, .rstn_in, .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.sample_valid_in(valid), .live_x_in(lx), .live_y_in(ly), .live_z_in(lz),
		.stored_x_in(sx), .stored_y_in(sy), .stored_z_in(sz), .sample_x_out(ox),
		.sample_y_out(oy), .sample_z_out(oz), .x_new_data_event_out(ex),
		.y_new_data_event_out(ey), .z_new_data_event_out(ez), .delta_x_out(dx),
		.delta_y_out(dy), .delta_z_out(dz), .cutoff_select_out(cut), .orient_update_in(upd),
		.orient_lockout_in(lo), .orient_back_front_in(bf), .orient_portrait_landscape_in(pl),
		.orientation_interrupt_enable_in(ien), .orientation_interrupt_source_out(isrc),
		.orientation_detect_enable_out(den), .debounce_counter_mode_out(dbm),
		.lockout_threshold_offset_out(gof));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] rmask(input logic [7:0] a);
		return a == 8'h16 ? 8'h87 : a == 8'h17 ? 8'h03 : a == 8'h1A ? 8'hC7 : 8'h00;
	endfunction
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// Saturates a scaled difference to the signed 12-bit delta range.
	function automatic logic [11:0] hp_out(input int d);
		int q;
		q = d >>> 12;
		if (q > 2047)
			return 12'h7FF;
		if (q < -2048)
			return 12'h800;
		return q[11:0];
	endfunction
	// Reference high-pass step for one axis; the corner shift follows the cutoff code.
	task automatic hp_chk(input int k, input logic [11:0] x, input logic [11:0] seen);
		int d;
		d = $signed(x) * 4096 - lp[k];
		check("delta", seen, hp_out(d));
		lp[k] += d >>> (4 + seed[9:8]);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
		u_host.rd(a, v, ok);
		check("rvalid", ok, 1);
		check("rdata", v, x);
	endtask
	task automatic orient(input logic l, input logic [1:0] b, input logic [2:0] p);
		@(posedge mclk_in);
		#1 upd = 1;
		lo = l;
		bf = b;
		pl = p;
		@(posedge mclk_in);
		#1 upd = 0;
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000 err_count++;
		results();
	end
	initial begin
		repeat (3) @(posedge mclk_in);
		#1 rstn_in = 1;
		check("dbm", dbm, 1);
		check("gof", gof, 3);
		check("den", den, 0);
		for (int a = 8'h16; a <= 8'h1B; a++) rdchk(a[7:0], a == 8'h1A ? 8'h83 : 8'h00);
		for (int i = 0; i < 6; i++) begin
			for (int a = 8'h16; a <= 8'h1B; a++) begin
				seed = lfsr(seed);
				if (a == 8'h1A)
					e = seed[7:0];
				u_host.wr(a[7:0], seed[7:0]);
				rdchk(a[7:0], seed[7:0] & rmask(a[7:0]));
			end
			check("cfg", {dbm, den, gof}, {e[7], e[6], e[2:0]});
		end
		u_host.wr(8'h18, 8'hFF);
		u_host.wr(8'h19, 8'hFF);
		rdchk(8'h18, 8'h00);
		rdchk(8'h19, 8'h00);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			u_host.wr(8'h16, seed[7:0] & 8'h87);
			u_host.wr(8'h17, seed[9:8]);
			@(posedge mclk_in);
			#1 check("cut", cut, seed[9:8]);
			{lx, ly, lz} = {seed, seed[3:0]};
			{sx, sy, sz} = ~{seed[3:0], seed};
			valid = 1;
			@(posedge mclk_in);
			#1 valid = 0;
			check("sample", {ox, oy, oz}, seed[7] ? {sx, sy, sz} : {lx, ly, lz});
			check("event", {ez, ey, ex}, seed[2:0]);
			hp_chk(0, lx, dx);
			hp_chk(1, ly, dy);
			hp_chk(2, lz, dz);
		end
		u_host.wr(8'h1A, 8'h83);
		orient(1, 2'b10, 3'b100);
		rdchk(8'h18, 8'h00);
		u_host.wr(8'h1A, 8'hC3);
		prev = 8'h00;
		for (int i = 1; i < 6; i++) begin
			e = {1'b1, i[0], 1'b0, 3'(i % 5), 2'(i % 3)};
			orient(e[6], e[1:0], e[4:2]);
			check("isrc", isrc, 1);
			rdchk(8'h18, e);
			check("isrc", isrc, 0);
			rdchk(8'h18, e & 8'h7F);
			rdchk(8'h19, prev);
			prev = e & 8'h7F;
		end
		orient(prev[6], prev[1:0], prev[4:2]);
		rdchk(8'h18, prev);
		ien = 0;
		orient(0, 2'b01, 3'b011);
		check("isrc", isrc, 0);
		ien = 1;
		rdchk(8'h19, prev);
		rdchk(8'h18, 8'h8D);
		// A change arriving with a status read must leave the flag set.
		fork
			orient(1, 2'b01, 3'b011);
			u_host.rd(8'h18, v, ok);
		join
		check("rdata", v, 8'h0D);
		check("isrc", isrc, 1);
		rdchk(8'h18, 8'hCD);
		results();
	end
endmodule
bind ornt_regbank ornt_regbank_monitor u_mon (.mclk_in, .rstn_in, .reg_addr_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .sample_valid_in, .sample_x_out, .x_new_data_event_out,
	.y_new_data_event_out, .z_new_data_event_out, .delta_x_out, .orient_update_in,
	.orientation_interrupt_enable_in, .orientation_interrupt_source_out);

// ==== testbench/ornt_host_model.sv ====
// Host side of the register path: single-byte register writes and reads.
// Assumes one-cycle strobes and read data valid one cycle after the strobe.
`timescale 1ns/1ns
module ornt_host_model (
	input  logic       mclk_in,
	output logic [7:0] reg_addr_out,
	output logic       reg_wr_out,
	output logic       reg_rd_out,
	output logic [7:0] reg_wdata_out,
	input  logic [7:0] reg_rdata_in,
	input  logic       reg_rvalid_in
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_wdata_out = 8'h00;
	end
	// Released lines show the inverse so stale values are never mistaken for live ones.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		#1 reg_addr_out = a;
		reg_wdata_out = d;
		reg_wr_out = 1'b1;
		@(posedge mclk_in);
		#1 reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge mclk_in);
		#1 reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(posedge mclk_in);
		#1 reg_rd_out = 1'b0;
		reg_addr_out = ~a;
		d = reg_rdata_in;
		ok = reg_rvalid_in;
	endtask
endmodule

// ==== testbench/ornt_regbank_monitor.sv ====
// Concurrent checks on the ports of the orientation register bank.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ns
module ornt_regbank_monitor (
	input logic        mclk_in,
	input logic        rstn_in,
	input logic [7:0]  reg_addr_in,
	input logic        reg_wr_in,
	input logic        reg_rd_in,
	input logic [7:0]  reg_rdata_out,
	input logic        sample_valid_in,
	input logic [11:0] sample_x_out,
	input logic        x_new_data_event_out,
	input logic        y_new_data_event_out,
	input logic        z_new_data_event_out,
	input logic [11:0] delta_x_out,
	input logic        orient_update_in,
	input logic        orientation_interrupt_enable_in,
	input logic        orientation_interrupt_source_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	wire rd_ok  = reg_rd_in && !reg_wr_in;
	wire rd_hit = rd_ok && reg_addr_in == 8'h18;
	wire rd_st  = rd_hit && !orient_update_in;
	function automatic logic [7:0] zmask(input logic [7:0] a);
		case (a)
			8'h16: return 8'h78;
			8'h17: return 8'hFC;
			8'h18: return 8'h20;
			8'h19: return 8'hA0;
			8'h1A: return 8'h38;
			default: return 8'hFF;
		endcase
	endfunction
	a_read_drops_source: assert property (
		rd_st |=> !orientation_interrupt_source_out) else $error("source stays after read");
	a_flag_stands_unread: assert property (
		orientation_interrupt_source_out && orientation_interrupt_enable_in && !rd_hit
		|=> orientation_interrupt_source_out) else $error("source lost without read");
	a_source_needs_enable: assert property (
		!orientation_interrupt_enable_in |=> !orientation_interrupt_source_out)
		else $error("source without enable");
	a_status_read_clear: assert property (
		rd_st ##1 !orient_update_in ##1 rd_st |=> !reg_rdata_out[7])
		else $error("flag not cleared by read");
	a_event_needs_sample: assert property (
		!sample_valid_in |=> !(x_new_data_event_out | y_new_data_event_out
		| z_new_data_event_out)) else $error("event without sample");
	a_sample_out_hold: assert property (
		!sample_valid_in |=> $stable(sample_x_out)) else $error("sample output moved");
	a_delta_out_hold: assert property (
		!sample_valid_in |=> $stable(delta_x_out)) else $error("delta output moved");
	a_fixed_zero_bits: assert property (
		rd_ok |=> (reg_rdata_out & zmask($past(reg_addr_in))) == 8'h00)
		else $error("fixed zero bit set");
	c_status_flag_read: cover property (rd_st ##1 reg_rdata_out[7]);
	c_source_raised: cover property ($rose(orientation_interrupt_source_out));
	c_event_seen: cover property (sample_valid_in ##1 x_new_data_event_out);
endmodule
